// ### common/sram_port_consts.svh
// Overview of operation
// R1: memory stores data only while select and write strobe overlap low.
// R2: controller starts a write by driving select and write strobe low.
// R3: write ends when select or write strobe rises, whichever first.
// R4: data setup and hold are timed to the write-ending rising edge.
// R5: reads keep write strobe high; select and output enable low.
// R6: memory floats its data pins while output enable is high.
// R7: select rising with write strobe keeps memory outputs floating.
// R8: controller never drives data while memory drives the bus.
// R9: strobe pulse with output enable low covers float delay plus setup.
// R10: read address is valid no later than select falling.
// R11: read data sampled no earlier than access delay; cycle that long.
// R12: memory holds old read data 5 ns after address change.
// R13: read data valid at most 55/70 ns after select falls.
// R14: read data valid at most 25/35 ns after output enable falls.
// R15: address valid at least 45/60 ns before write end.
// R16: address may change at write start, held until write end.
// R17: write data valid at least 25/30 ns before write end.
// R18: write data stable up to write end; zero hold afterwards.
// R19: memory deselected while select high: floats and stands by.
// R20: 15-bit address, 8-bit data bus, 32768 byte locations.
`ifndef SRAM_PORT_CONSTS_SVH
`define SRAM_PORT_CONSTS_SVH
`define CLK_PERIOD_NS 20
// slow grade figures cover both grades
`define ADDRESS_ACCESS_DELAY_NS 70
`define ADDRESS_SETUP_TO_WRITE_END_NS 60
`define WRITE_DATA_SETUP_NS 30
`define WRITE_TO_FLOAT_DELAY_NS 25
`define READ_CYCLE_MIN_NS 70
// least times round up
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_WAIT_CYC `CYC_UP(`ADDRESS_ACCESS_DELAY_NS)
`define WRITE_PULSE_CYC `CYC_UP(`ADDRESS_SETUP_TO_WRITE_END_NS)
`define FLOAT_WAIT_CYC `CYC_UP(`WRITE_TO_FLOAT_DELAY_NS)
`define ADDR_W 15
`define DATA_W 8
`endif

// ### common/sram_port_pkg.sv
`default_nettype none
package sram_port_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_READ = 3'b001,
		ST_WRITE = 3'b010,
		ST_TURN = 3'b011
	} port_state_t;
endpackage
`default_nettype wire

// ### design/sram_port_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "sram_port_consts.svh"
module sram_port_host
	import sram_port_pkg::*;
#(
	parameter int ADDR_W = `ADDR_W,
	parameter int DATA_W = `DATA_W,
	parameter int READ_CYC = `READ_WAIT_CYC,
	parameter int WRITE_CYC = `WRITE_PULSE_CYC,
	parameter int TURN_CYC = `FLOAT_WAIT_CYC
)
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [DATA_W-1:0] req_wdata,
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_rdata,
	output logic [ADDR_W-1:0] mem_addr,
	output logic select_n,
	output logic write_strobe_n,
	output logic output_enable_n,
	input wire logic [DATA_W-1:0] mem_data_in,
	output logic [DATA_W-1:0] mem_data_out,
	output logic mem_data_oe
);
	// ==========================================================
	// sequencer
	port_state_t state_r, state_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	logic [ADDR_W-1:0] addr_r, addr_nxt;
	logic [DATA_W-1:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
	logic sel_r, sel_nxt, we_r, we_nxt, oe_r, oe_nxt, doe_r, doe_nxt;
	logic rsp_r, rsp_nxt;
	// read data from the pins passes three flops
	logic [DATA_W-1:0] sync1_r, sync2_r, sync3_r;

	assign req_ready = (state_r == ST_IDLE);

	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		addr_nxt = addr_r;
		wdata_nxt = wdata_r;
		rdata_nxt = rdata_r;
		sel_nxt = sel_r;
		we_nxt = we_r;
		oe_nxt = oe_r;
		doe_nxt = doe_r;
		rsp_nxt = 1'b0;
		case (state_r)
			ST_IDLE:
			begin
				if (req_valid)
				begin
					// address set on the same edge that select falls
					addr_nxt = req_addr; // see R10 see R16 see R20
					wdata_nxt = req_wdata;
					sel_nxt = 1'b1;
					cnt_nxt = 8'h00;
					if (req_write)
					begin
						// oe stays high so memory never drives
						we_nxt = 1'b1; // see R2 see R8 see R9
						doe_nxt = 1'b1; // see R17
						state_nxt = ST_WRITE;
					end
					else
					begin
						oe_nxt = 1'b1; // see R5
						state_nxt = ST_READ;
					end
				end
			end
			ST_READ:
			begin
				cnt_nxt = cnt_r + 8'h01;
				// +3 covers the pin synchroniser
				if (cnt_r == 8'(READ_CYC + 3))
				begin
					rdata_nxt = sync3_r; // see R11 see R13 see R14
					rsp_nxt = 1'b1;
					sel_nxt = 1'b0;
					oe_nxt = 1'b0;
					cnt_nxt = 8'h00;
					state_nxt = ST_TURN;
				end
			end
			ST_WRITE:
			begin
				cnt_nxt = cnt_r + 8'h01;
				if (cnt_r == 8'(WRITE_CYC - 1))
				begin
					// both rise together; data and address held
					sel_nxt = 1'b0; // see R3 see R4 see R15 see R18
					we_nxt = 1'b0;
					rsp_nxt = 1'b1;
					cnt_nxt = 8'h00;
					state_nxt = ST_TURN;
				end
			end
			ST_TURN:
			begin
				// gap lets the memory release the bus
				doe_nxt = 1'b0;
				cnt_nxt = cnt_r + 8'h01;
				if (cnt_r == 8'(TURN_CYC - 1))
					state_nxt = ST_IDLE;
			end
			default:
			begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_r <= ST_IDLE;
			cnt_r <= 8'h00;
			addr_r <= '0;
			wdata_r <= '0;
			rdata_r <= '0;
			sel_r <= 1'b0;
			we_r <= 1'b0;
			oe_r <= 1'b0;
			doe_r <= 1'b0;
			rsp_r <= 1'b0;
			sync1_r <= '0;
			sync2_r <= '0;
			sync3_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
			rdata_r <= rdata_nxt;
			sel_r <= sel_nxt;
			we_r <= we_nxt;
			oe_r <= oe_nxt;
			doe_r <= doe_nxt;
			rsp_r <= rsp_nxt;
			sync1_r <= mem_data_in;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	assign mem_addr = addr_r;
	assign select_n = ~sel_r;
	assign write_strobe_n = ~we_r;
	assign output_enable_n = ~oe_r;
	assign mem_data_out = wdata_r;
	assign mem_data_oe = doe_r;
	assign rsp_valid = rsp_r;
	assign rsp_rdata = rdata_r;

	// ==========================================================
	// assertions
	property p_write_pulse;
		@(posedge sys_clk) disable iff (sys_rst)
		$fell(write_strobe_n) |-> !write_strobe_n [*3];
	endproperty
	a_write_pulse: assert property (p_write_pulse) // see R15
		else $error("write strobe pulse too short");

	property p_no_contention;
		@(posedge sys_clk) disable iff (sys_rst)
		!output_enable_n |-> !mem_data_oe;
	endproperty
	a_no_contention: assert property (p_no_contention) // see R8
		else $error("data driven while memory output enabled");

	property p_read_strobe_high;
		@(posedge sys_clk) disable iff (sys_rst)
		!output_enable_n |-> write_strobe_n;
	endproperty
	a_read_strobe_high: assert property (p_read_strobe_high) // see R5
		else $error("write strobe low during read");

	property p_addr_hold;
		@(posedge sys_clk) disable iff (sys_rst)
		(!select_n && !$fell(select_n)) |-> $stable(mem_addr);
	endproperty
	a_addr_hold: assert property (p_addr_hold) // see R10
		else $error("address moved while selected");

	property p_data_hold;
		@(posedge sys_clk) disable iff (sys_rst)
		$rose(write_strobe_n) |-> $stable(mem_data_out) && mem_data_oe;
	endproperty
	a_data_hold: assert property (p_data_hold) // see R18
		else $error("write data changed at write end");

	property p_write_both;
		@(posedge sys_clk) disable iff (sys_rst)
		$fell(write_strobe_n) |-> $fell(select_n);
	endproperty
	a_write_both: assert property (p_write_both) // see R2
		else $error("write strobe without select");

	property p_read_time;
		@(posedge sys_clk) disable iff (sys_rst)
		$fell(output_enable_n) |-> !output_enable_n [*4];
	endproperty
	a_read_time: assert property (p_read_time) // see R11
		else $error("read cycle too short");

	property p_write_end;
		@(posedge sys_clk) disable iff (sys_rst)
		$fell(write_strobe_n) |-> ##3 $rose(write_strobe_n);
	endproperty
	a_write_end: assert property (p_write_end) // see R3
		else $error("write did not end on time");
endmodule
`default_nettype wire

// ### verif/sram_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
module sram_dev_model #(
	parameter int ACCESS_NS = 70,
	parameter int HOLD_NS = 5
)
(
	input wire logic [14:0] mem_addr,
	input wire logic select_n,
	input wire logic write_strobe_n,
	input wire logic output_enable_n,
	input wire logic [7:0] mem_data_out,
	input wire logic mem_data_oe,
	output logic [7:0] mem_data_in,
	output logic clash
);
	logic [7:0] mem [0:32767];
	wire we_n = select_n | write_strobe_n;
	// floats unless selected, enabled and not writing
	wire drive = !select_n && write_strobe_n &&
		!output_enable_n;
	wire [15:0] key = {drive, mem_addr};
	wire [15:0] key_d;
	// inertial delay: data valid only once address and select settle
	// oe access is shorter, so one delay covers it pessimistically
	assign #ACCESS_NS key_d = key;
	initial
	begin
		clash = 1'b0;
		for (int i = 0; i < 32768; i++)
			mem[i] = 8'h00;
	end
	always @(posedge we_n)
		if (mem_data_oe)
			mem[mem_addr] <= mem_data_out;
	always @*
		if (drive && mem_data_oe)
			clash = 1'b1;
	// not yet valid or floating: show garbage, never the stored byte
	// old byte stays up for the hold time after any change
	assign #HOLD_NS mem_data_in = mem_data_oe ? mem_data_out :
		(drive && key_d === key) ? mem[mem_addr] : ~mem[mem_addr];
endmodule
`default_nettype wire

// ### verif/async_sram_read_write_port_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module async_sram_read_write_port_tb_top;
	logic sys_clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, req_write = 1'b0;
	logic [14:0] req_addr = 15'h0000, mem_addr;
	logic [7:0] req_wdata = 8'h00, rsp_rdata, mem_data_in, mem_data_out;
	logic req_ready, rsp_valid, select_n, write_strobe_n, output_enable_n;
	logic mem_data_oe, clash;
	int n_fail = 0, n_checks = 0;
	sram_port_host u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
		.req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata), .mem_addr(mem_addr), .select_n(select_n),
		.write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n),
		.mem_data_in(mem_data_in), .mem_data_out(mem_data_out),
		.mem_data_oe(mem_data_oe));
	sram_dev_model u_mem (.mem_addr(mem_addr), .select_n(select_n),
		.write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n),
		.mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe),
		.mem_data_in(mem_data_in), .clash(clash));
	initial
		forever #10 sys_clk = ~sys_clk;
	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_bit(input logic g, input logic e);
		chk_byte({7'h00, g}, {7'h00, e});
	endtask
	task automatic complete_run;
		if (n_fail == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	function automatic logic [7:0] pat(input logic [14:0] a);
		return a[7:0] ^ a[14:7] ^ 8'h3c;
	endfunction
	// one request; pin order and hold checked each cycle of the access
	task automatic xfer(input logic w, input logic [14:0] a);
		int n, lo;
		logic bad;
		n = 0;
		lo = 0;
		bad = 1'b0;
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= pat(a);
		do @(negedge sys_clk); while (req_ready !== 1'b1 && ++n < 50);
		@(posedge sys_clk);
		req_valid <= 1'b0;
		n = 0;
		do
		begin
			@(negedge sys_clk);
			n++;
			lo += w ? !write_strobe_n : !select_n;
			bad |= req_ready;
			if (w)
				bad |= !output_enable_n | (!write_strobe_n & (select_n
					| !mem_data_oe | mem_data_out !== pat(a) | mem_addr !== a));
			else
				bad |= !write_strobe_n | (!select_n & mem_addr !== a);
		end
		while (rsp_valid !== 1'b1 && n < 50);
		chk_bit(rsp_valid, 1'b1);
		chk_bit(bad, 1'b0);
		chk_bit(lo >= (w ? 3 : 4), 1'b1);
		if (!w)
			chk_byte(rsp_rdata, pat(a));
		@(posedge sys_clk);
	endtask
	// boundary addresses, back to back, with an overwrite
	task automatic t_fill;
		logic [14:0] tbl [4] = '{15'h0000, 15'h7fff, 15'h2aaa, 15'h5555};
		foreach (tbl[i])
			xfer(1'b1, tbl[i]);
		xfer(1'b1, 15'h7fff);
		foreach (tbl[i])
			xfer(1'b0, tbl[i]);
	endtask
	// reset in mid-write must release every pin at once
	task automatic t_reset_mid;
		req_valid <= 1'b1;
		req_write <= 1'b1;
		req_addr <= 15'h0001;
		repeat (3) @(posedge sys_clk);
		req_valid <= 1'b0;
		sys_rst <= 1'b1;
		@(negedge sys_clk);
		chk_bit(select_n & write_strobe_n & output_enable_n, 1'b1);
		chk_bit(mem_data_oe | rsp_valid, 1'b0);
		chk_bit(req_ready, 1'b1);
		@(posedge sys_clk);
		sys_rst <= 1'b0;
		xfer(1'b0, 15'h5555);
	endtask
	initial
	begin
		repeat (8) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t_fill;
		t_reset_mid;
		chk_bit(clash, 1'b0);
		complete_run;
	end
	initial
	begin
		#100000;
		n_fail++;
		complete_run;
	end
endmodule
`default_nettype wire
